// file: core/fpo_fan_output_one.sv
// Override, lock, spin-up and pulse generation for the first fan output
//
// Contract
// [RL1] Manual enable applies the manual duty code
// [RL2] Polarity bit inverts output sense at full
// [RL3] Bound hot event sets lock only when enabled
// [RL4] Lock flag forces full duty on output
// [RL5] Writing zero clears lock, normal control resumes
// [RL6] Lock flag ignores configuration write protection
// [RL7] Manual code field bits 7:4, sixteen codes
// [RL8] Manual code read returns applied duty code
// [RL9] Readback may show larger arbitrated duty code
// [RL10] Manual code reads zero during spin-up
// [RL11] Spin-up duty code bits 3:0 during spin-up
// [RL12] Spin-up duty code zero disables spin-up
// [RL13] Duration code: bit 4 top, bits 7:5
// [RL14] Zero to nonzero duty starts spin-up sequence
// [RL15] Short durations 100 ms to 4 s
// [RL16] Long durations 6 s to 20 s, 2 s steps
// [RL17] Largest requested duty among bound sources wins
// [RL18] Hot events act only when binding set
// [RL19] Duty code mapping is a parameterised table
// [RL20] After spin-up, arbitrated duty resumes
`timescale 1ns/1ps

module fpo_fan_output_one #(
    parameter int                MS_CYCLES = fpo_pkg::MS_CYCLES,
    parameter int                PWM_DIV   = 16,
    // [RL19] Duty code table
    parameter logic [15:0][7:0]  DUTY_MAP  = {8'hFF, 8'hEE, 8'hDD, 8'hCC,
                                              8'hBB, 8'hAA, 8'h99, 8'h88,
                                              8'h77, 8'h66, 8'h55, 8'h44,
                                              8'h33, 8'h22, 8'h11, 8'h00}
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    output logic      [7:0]  regRdData,
    // Global configuration write protection
    input  wire logic        configWriteLock,
    // Control sources
    input  wire logic        processorHotBinding,
    input  wire logic        processorHotEvent,
    input  wire logic [3:0]  processorHotDutyCode,
    input  wire logic [3:0]  tableDutyCode,
    // Fan side
    output logic             fanOutputOne,
    output logic [3:0]       appliedDutyCode,
    output logic             spinupActive
);

    localparam int CW = fpo_pkg::CODE_W;
    localparam logic [CW-1:0] CODE_ZERO = '0;
    localparam logic [7:0]    FULL_DUTY = 8'hFF;
    localparam int TICK_W = $clog2(MS_CYCLES + 1);
    localparam int DIV_W  = $clog2(PWM_DIV + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MS_CYCLES - 1);
    localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(PWM_DIV - 1);
    localparam logic [7:0]        PWM_LAST  = 8'hFE;

    typedef enum logic [0:0] {
        FPO_RUN,
        FPO_SPIN
    } fpo_state_e;

    // Register state
    logic            manualEn_q;
    logic            polarity_q;
    logic            lockEn_q;
    logic            lockFlag_q;
    logic [CW-1:0]   manualCode_q;
    logic [CW-1:0]   spinCode_q;
    logic [CW-1:0]   durCode_q;

    // Spin-up and timing state
    fpo_state_e              state_q;
    fpo_state_e              state_d;
    logic [fpo_pkg::MS_W-1:0] msLeft_q;
    logic [fpo_pkg::MS_W-1:0] msLeft_d;
    logic [TICK_W-1:0]       tickCnt_q;
    logic [DIV_W-1:0]        divCnt_q;
    logic [7:0]              pwmCnt_q;
    logic [CW-1:0]           prevReq_q;

    // Decodes
    wire logic hitOverride = regAddr == fpo_pkg::OVERRIDE_CTRL_ADDR;
    wire logic hitSpinup   = regAddr == fpo_pkg::SPINUP_CTRL_ADDR;
    wire logic wrOverride  = regWrEn && hitOverride;
    wire logic wrCfgOvr    = wrOverride && !configWriteLock;
    wire logic wrCfgSpin   = regWrEn && hitSpinup && !configWriteLock;
    wire logic msTick      = tickCnt_q == TICK_LAST;
    wire logic pwmTick     = divCnt_q == DIV_LAST;

    // [RL18] Hot gated by binding
    wire logic hotBound = processorHotBinding && processorHotEvent;
    wire logic [CW-1:0] hotReq = processorHotBinding ? processorHotDutyCode : CODE_ZERO;
    // [RL1] Manual request
    wire logic [CW-1:0] manualReq = manualEn_q ? manualCode_q : CODE_ZERO;
    // [RL17] Largest request wins
    wire logic [CW-1:0] maxA = (manualReq > tableDutyCode) ? manualReq : tableDutyCode;
    wire logic [CW-1:0] reqCode = (hotReq > maxA) ? hotReq : maxA;

    // [RL13] Duration code assembly
    wire logic [CW-1:0] durField = {regWrData[fpo_pkg::DUR_TOP_BIT],
                                    regWrData[fpo_pkg::DUR_LOW_LSB +: 3]};
    // [RL15] [RL16] Duration decode
    wire logic [fpo_pkg::MS_W-1:0] durMs = fpo_pkg::durationMs(durCode_q);

    // [RL14] [RL12] Spin-up trigger on zero to nonzero
    wire logic spinStart = (prevReq_q == CODE_ZERO) && (reqCode != CODE_ZERO)
                           && (spinCode_q != CODE_ZERO) && (durMs != '0);
    wire logic inSpin = state_q == FPO_SPIN;

    // [RL11] Spin-up code while active, [RL20] arbitrated otherwise
    wire logic [CW-1:0] runCode = inSpin ? spinCode_q : reqCode;
    // [RL4] Lock forces full duty
    wire logic [7:0] dutyLevel = lockFlag_q ? FULL_DUTY : DUTY_MAP[runCode];
    wire logic [CW-1:0] shownCode = lockFlag_q ? {CW{1'b1}} : runCode;

    // [RL2] Full duty is a steady level, sense chosen by polarity
    wire logic rawPulse = (dutyLevel == FULL_DUTY) || (pwmCnt_q < dutyLevel);
    wire logic pinLevel = rawPulse ^ polarity_q;

    // [RL8] [RL9] [RL10] Readback shows applied code, zero in spin-up
    wire logic [CW-1:0] readCode = inSpin ? CODE_ZERO : shownCode;
    wire logic [7:0] rdOverride = {readCode, lockFlag_q, lockEn_q, polarity_q, manualEn_q};
    wire logic [7:0] rdSpinup   = {durCode_q[CW-2:0], durCode_q[CW-1], spinCode_q};
    wire logic [7:0] rdMux = hitOverride ? rdOverride : (hitSpinup ? rdSpinup : 8'h00);

    // Configuration bits, held by write protection
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            manualEn_q   <= fpo_pkg::OVERRIDE_CTRL_RST[fpo_pkg::MANUAL_EN_BIT];
            polarity_q   <= fpo_pkg::OVERRIDE_CTRL_RST[fpo_pkg::POLARITY_BIT];
            lockEn_q     <= fpo_pkg::OVERRIDE_CTRL_RST[fpo_pkg::LOCK_EN_BIT];
            manualCode_q <= fpo_pkg::OVERRIDE_CTRL_RST[fpo_pkg::MANUAL_CODE_LSB +: CW];
        end
        else if (wrCfgOvr)
        begin
            // [RL7] Manual code field
            manualEn_q   <= regWrData[fpo_pkg::MANUAL_EN_BIT];
            polarity_q   <= regWrData[fpo_pkg::POLARITY_BIT];
            lockEn_q     <= regWrData[fpo_pkg::LOCK_EN_BIT];
            manualCode_q <= regWrData[fpo_pkg::MANUAL_CODE_LSB +: CW];
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            spinCode_q <= fpo_pkg::SPINUP_CTRL_RST[fpo_pkg::SPIN_CODE_LSB +: CW];
            durCode_q  <= {fpo_pkg::SPINUP_CTRL_RST[fpo_pkg::DUR_TOP_BIT],
                           fpo_pkg::SPINUP_CTRL_RST[fpo_pkg::DUR_LOW_LSB +: 3]};
        end
        else if (wrCfgSpin)
        begin
            spinCode_q <= regWrData[fpo_pkg::SPIN_CODE_LSB +: CW];
            durCode_q  <= durField;
        end
    end

    // Lock flag: set wins over a clearing write
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            lockFlag_q <= fpo_pkg::OVERRIDE_CTRL_RST[fpo_pkg::LOCK_FLAG_BIT];
        end
        // [RL3] Set only when enabled
        else if (lockEn_q && hotBound)
        begin
            lockFlag_q <= 1'b1;
        end
        // [RL5] [RL6] Zero write clears, protection ignored
        else if (wrOverride && !regWrData[fpo_pkg::LOCK_FLAG_BIT])
        begin
            lockFlag_q <= 1'b0;
        end
    end

    // Spin-up sequencer
    always_comb
    begin
        state_d  = state_q;
        msLeft_d = msLeft_q;
        case (state_q)
            FPO_RUN:
            begin
                if (spinStart)
                begin
                    state_d  = FPO_SPIN;
                    msLeft_d = durMs;
                end
            end
            FPO_SPIN:
            begin
                // [RL20] Resume arbitration at expiry
                if (msTick)
                begin
                    if (msLeft_q <= fpo_pkg::MS_W'(1))
                    begin
                        state_d  = FPO_RUN;
                        msLeft_d = '0;
                    end
                    else
                    begin
                        msLeft_d = msLeft_q - fpo_pkg::MS_W'(1);
                    end
                end
            end
            default:
            begin
                state_d  = FPO_RUN;
                msLeft_d = '0;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_q   <= FPO_RUN;
            msLeft_q  <= '0;
            prevReq_q <= '0;
        end
        else
        begin
            state_q   <= state_d;
            msLeft_q  <= msLeft_d;
            prevReq_q <= reqCode;
        end
    end

    // Millisecond enable, restarted with each spin-up
    always_ff @(posedge clock)
    begin
        if (rst || msTick || (state_q == FPO_RUN))
        begin
            tickCnt_q <= '0;
        end
        else
        begin
            tickCnt_q <= tickCnt_q + TICK_W'(1);
        end
    end

    // Pulse period counter
    always_ff @(posedge clock)
    begin
        if (rst || pwmTick)
        begin
            divCnt_q <= '0;
        end
        else
        begin
            divCnt_q <= divCnt_q + DIV_W'(1);
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pwmCnt_q <= '0;
        end
        else if (pwmTick)
        begin
            pwmCnt_q <= (pwmCnt_q == PWM_LAST) ? 8'h00 : pwmCnt_q + 8'h01;
        end
    end

    // Registered outputs
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            fanOutputOne    <= 1'b0;
            appliedDutyCode <= '0;
            spinupActive    <= 1'b0;
            regRdData       <= 8'h00;
        end
        else
        begin
            fanOutputOne    <= pinLevel;
            appliedDutyCode <= shownCode;
            spinupActive    <= inSpin;
            if (regRdEn)
            begin
                regRdData <= rdMux;
            end
        end
    end

endmodule // fpo_fan_output_one

// file: core/fpo_pkg.sv
// Shared constants for the first fan output control block
package fpo_pkg;

    // Register offsets
    localparam logic [7:0] OVERRIDE_CTRL_ADDR = 8'hC9;
    localparam logic [7:0] SPINUP_CTRL_ADDR   = 8'hCA;

    // Reset values
    localparam logic [7:0] OVERRIDE_CTRL_RST  = 8'h00;
    localparam logic [7:0] SPINUP_CTRL_RST    = 8'h00;

    // Override control field positions
    localparam int MANUAL_EN_BIT   = 0;
    localparam int POLARITY_BIT    = 1;
    localparam int LOCK_EN_BIT     = 2;
    localparam int LOCK_FLAG_BIT   = 3;
    localparam int MANUAL_CODE_LSB = 4;

    // Spin-up control field positions
    localparam int SPIN_CODE_LSB   = 0;
    localparam int DUR_TOP_BIT     = 4;
    localparam int DUR_LOW_LSB     = 5;

    localparam int CODE_W          = 4;
    localparam int MS_W            = 15;

    // Timing base
    localparam int CLOCK_HZ        = 40_000_000;
    localparam int TICK_MS         = 1;
    localparam int MS_CYCLES       = CLOCK_HZ / 1000 * TICK_MS;

    // Spin-up durations in milliseconds
    localparam logic [MS_W-1:0] DUR_100MS   = 15'd100;
    localparam logic [MS_W-1:0] DUR_250MS   = 15'd250;
    localparam logic [MS_W-1:0] DUR_400MS   = 15'd400;
    localparam logic [MS_W-1:0] DUR_700MS   = 15'd700;
    localparam logic [MS_W-1:0] DUR_1S      = 15'd1000;
    localparam logic [MS_W-1:0] DUR_2S      = 15'd2000;
    localparam logic [MS_W-1:0] DUR_4S      = 15'd4000;
    localparam logic [MS_W-1:0] DUR_LONG_BASE = 15'd6000;
    localparam logic [MS_W-1:0] DUR_LONG_STEP = 15'd2000;

    // Duration code to milliseconds, zero means disabled
    function automatic logic [MS_W-1:0] durationMs(input logic [CODE_W-1:0] code);
        logic [MS_W-1:0] ms;
        ms = '0;
        if (code[CODE_W-1])
        begin
            ms = DUR_LONG_BASE + MS_W'(DUR_LONG_STEP * code[CODE_W-2:0]);
        end
        else
        begin
            case (code[CODE_W-2:0])
                3'h1:    ms = DUR_100MS;
                3'h2:    ms = DUR_250MS;
                3'h3:    ms = DUR_400MS;
                3'h4:    ms = DUR_700MS;
                3'h5:    ms = DUR_1S;
                3'h6:    ms = DUR_2S;
                3'h7:    ms = DUR_4S;
                default: ms = '0;
            endcase
        end
        return ms;
    endfunction

endpackage

// file: verif/fpo_fan_model.sv
// Behavioural fan that counts the cycles its drive pin is high
`timescale 1ns/1ps

module fpo_fan_model (
    // Clock
    input  wire logic clock,
    // Drive pin and measurement
    input  wire logic fanPin,
    input  wire logic measClear,
    output int        highCount
);
    always_ff @(posedge clock)
    begin
        highCount <= measClear ? 0 : highCount + int'(fanPin);
    end
endmodule // fpo_fan_model

// file: verif/fpo_fan_output_one_chk.sv
// Checker for the first fan output control block
`timescale 1ns/1ps

module fpo_fan_output_one_chk #(
    parameter int PWM_DIV = 16
) (
    // Clock and reset
    input wire logic       clock,
    input wire logic       rst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrEn,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic       configWriteLock,
    // Control sources
    input wire logic       processorHotBinding,
    input wire logic       processorHotEvent,
    // Fan side
    input wire logic       fanOutputOne,
    input wire logic [3:0] appliedDutyCode,
    input wire logic       spinupActive
);
    logic [3:0] spinCode_q;
    logic       lockEn_q;
    int         steady_q;
    wire        wrOk   = regWrEn && !configWriteLock;
    wire        rdOvr  = regRdEn && regAddr == fpo_pkg::OVERRIDE_CTRL_ADDR;
    wire        rdNone = regRdEn && regAddr != 8'hC9 && regAddr != 8'hCA;
    wire        full   = appliedDutyCode == 4'hF || appliedDutyCode == 4'h0;
    wire        hotHit = processorHotEvent && processorHotBinding && lockEn_q;

    // Shadow copies of written fields; steady counter for extreme codes
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            spinCode_q <= 4'h0;
            lockEn_q   <= 1'b0;
        end
        else if (wrOk && regAddr == fpo_pkg::SPINUP_CTRL_ADDR)
            spinCode_q <= regWrData[3:0];
        else if (wrOk && regAddr == fpo_pkg::OVERRIDE_CTRL_ADDR)
            lockEn_q <= regWrData[2];
        steady_q <= (full && !regWrEn && $stable(appliedDutyCode)) ? steady_q + 1 : 0;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_rdApplied;
        rdOvr && !spinupActive && !$past(spinupActive) && $stable(appliedDutyCode)
            |=> regRdData[7:4] == $past(appliedDutyCode);
    endproperty
    a_rdApplied: assert property (p_rdApplied) else $error("override read code wrong");
    property p_rdSpinZero;
        rdOvr && spinupActive && $past(spinupActive) |=> regRdData[7:4] == 4'h0;
    endproperty
    a_rdSpinZero: assert property (p_rdSpinZero) else $error("spin read not zero");
    property p_rdUnmapped;
        rdNone |=> regRdData == 8'h00;
    endproperty
    a_rdUnmapped: assert property (p_rdUnmapped) else $error("unmapped read nonzero");
    property p_steady;
        steady_q > 255 * PWM_DIV + 4 |-> $stable(fanOutputOne);
    endproperty
    a_steady: assert property (p_steady) else $error("extreme duty not steady");
    property p_spinCode;
        spinupActive && $past(spinupActive) |-> appliedDutyCode == spinCode_q;
    endproperty
    a_spinCode: assert property (p_spinCode) else $error("spin code not applied");
    property p_spinFromZero;
        $rose(spinupActive) |-> $past(appliedDutyCode, 2) == 4'h0;
    endproperty
    a_spinFromZero: assert property (p_spinFromZero) else $error("spin not from zero");
    property p_spinOff;
        $rose(spinupActive) |-> spinCode_q != 4'h0;
    endproperty
    a_spinOff: assert property (p_spinOff) else $error("spin with zero code");
    property p_lockFull;
        hotHit |-> ##[1:2] appliedDutyCode == 4'hF;
    endproperty
    a_lockFull: assert property (p_lockFull) else $error("lock not full duty");
    c_spin: cover property ($rose(spinupActive));
    c_lock: cover property (hotHit);
    c_read: cover property (rdOvr);
endmodule // fpo_fan_output_one_chk

bind fpo_fan_output_one fpo_fan_output_one_chk #(.PWM_DIV(PWM_DIV)) i_fpo_fan_output_one_chk (
    .clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .configWriteLock(configWriteLock), .processorHotBinding(processorHotBinding),
    .processorHotEvent(processorHotEvent), .fanOutputOne(fanOutputOne),
    .appliedDutyCode(appliedDutyCode), .spinupActive(spinupActive));

// file: verif/tb_top.sv
// Self-checking bench for the first fan output control block
`timescale 1ns/1ps

module tb_top;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic       regWrEn = 1'b0;
    logic       regRdEn = 1'b0;
    logic [7:0] regRdData;
    logic       cfgLock = 1'b0;
    logic       hotBind = 1'b0;
    logic       hotEvent = 1'b0;
    logic [3:0] hotCode = 4'h0;
    logic [3:0] tableCode = 4'h0;
    logic       fanOut;
    logic [3:0] applied;
    logic       spinOn;
    logic       measClear = 1'b0;
    int         highCount;
    int         fail_count = 0;
    int         comparisons = 0;

    fpo_fan_output_one #(.MS_CYCLES(2), .PWM_DIV(1)) i_fpo_fan_output_one (
        .clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .configWriteLock(cfgLock), .processorHotBinding(hotBind),
        .processorHotEvent(hotEvent), .processorHotDutyCode(hotCode),
        .tableDutyCode(tableCode), .fanOutputOne(fanOut),
        .appliedDutyCode(applied), .spinupActive(spinOn));
    fpo_fan_model i_fpo_fan_model (.clock(clock), .fanPin(fanOut), .measClear(measClear),
        .highCount(highCount));

    initial
    begin
        forever #12.5 clock = ~clock;
    end

    task automatic step(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step(1);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        step(1);
        regWrEn = 1'b0;
        step(2);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        step(1);
        regAddr = a;
        regRdEn = 1'b1;
        step(1);
        regRdEn = 1'b0;
        chk(regRdData, exp);
    endtask
    task automatic meas(input logic [7:0] d, input int exp);
        wr(8'hC9, d);
        step(300);
        measClear = 1'b1;
        step(1);
        measClear = 1'b0;
        step(255);
        chk(highCount, exp);
    endtask
    task automatic pulse(input logic [3:0] exp);
        hotEvent = 1'b1;
        step(1);
        hotEvent = 1'b0;
        step(2);
        chk(applied, exp);
    endtask
    task automatic spin(input logic [3:0] dur, input int ms);
        int c;
        c = 4;
        wr(8'hC9, 8'h00);
        wr(8'hCA, {dur[2:0], dur[3], 4'h7});
        wr(8'hC9, 8'h31);
        chk(spinOn, 1'b1);
        chk(applied, 4'h7);
        rd(8'hC9, 8'h01);
        while (spinOn === 1'b1 && c < 50000)
        begin
            step(1);
            c++;
        end
        if (c >= 50000)
        begin
            fail_count++;
            conclude();
        end
        chk(c >= ms * 2 - 1 && c <= ms * 2 + 3, 1'b1);
        step(2);
        chk(applied, 4'h3);
    endtask
    task automatic conclude();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        step(2);
        rst = 1'b0;
        rd(8'hC9, 8'h00);
        rd(8'hCA, 8'h00);
        rd(8'h55, 8'h00);
        for (int c = 0; c < 16; c++)
        begin
            wr(8'hC9, {c[3:0], 4'h1});
            chk(applied, c[3:0]);
            chk(spinOn, 1'b0);
            rd(8'hC9, {c[3:0], 4'h1});
        end
        wr(8'hC9, 8'h31);
        tableCode = 4'h9;
        hotCode = 4'hA;
        step(3);
        chk(applied, 4'h9);
        rd(8'hC9, 8'h91);
        hotBind = 1'b1;
        step(3);
        chk(applied, 4'hA);
        hotBind = 1'b0;
        tableCode = 4'h0;
        hotCode = 4'h0;
        meas(8'h51, 85);
        meas(8'h53, 170);
        meas(8'hF1, 255);
        meas(8'hF3, 0);
        wr(8'hC9, 8'h25);
        pulse(4'h2);
        hotBind = 1'b1;
        wr(8'hC9, 8'h21);
        pulse(4'h2);
        wr(8'hC9, 8'h25);
        pulse(4'hF);
        rd(8'hC9, 8'hFD);
        cfgLock = 1'b1;
        wr(8'hCA, 8'hFF);
        rd(8'hCA, 8'h00);
        wr(8'hC9, 8'h08);
        rd(8'hC9, 8'hFD);
        wr(8'hC9, 8'h00);
        chk(applied, 4'h2);
        rd(8'hC9, 8'h25);
        cfgLock = 1'b0;
        hotBind = 1'b0;
        spin(4'h1, 100);
        spin(4'h7, 4000);
        spin(4'h8, 6000);
        spin(4'hF, 20000);
        // Zero duration code: no spin-up
        wr(8'hC9, 8'h00);
        wr(8'hCA, 8'h07);
        wr(8'hC9, 8'h31);
        chk(spinOn, 1'b0);
        chk(applied, 4'h3);
        // Zero spin-up duty code: no spin-up
        wr(8'hC9, 8'h00);
        wr(8'hCA, 8'h20);
        wr(8'hC9, 8'h31);
        chk(spinOn, 1'b0);
        rd(8'hC9, 8'h31);
        conclude();
    end
endmodule // tb_top
